// File: shs_homing.sv
`timescale 1ns/1ps
// Summary of operation
// - Method 17 runs method 1 on negative limit.
// - Method 18 runs method 2 on positive limit.
// - Methods 19-30 reuse 3-14 with home switch.
// - Methods 33/34 move negative/positive until index.
// - Any switch during 33/34 flags error, stops.
// - Methods 35/37 capture position, no motion needed.
// - Capture happens on command bit 4 rising.
// - Active mode object mirrors accepted mode.
// - Homing motion starts on command bit 4 rising.
// - Opposite limit during switch methods flags error.
module shs_homing
    import shs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [15:0] obj_index,
    input  wire logic [7:0]  obj_sub,
    input  wire logic        obj_wr,
    input  wire logic        obj_rd,
    input  wire logic [31:0] obj_wdata,
    input  wire logic        drive_enabled,
    input  wire logic [31:0] actual_position,
    input  wire logic        index_pin,
    input  wire logic        neg_limit_pin,
    input  wire logic        pos_limit_pin,
    input  wire logic        home_pin,
    output logic      [31:0] obj_rdata_ff,
    output logic             obj_ack_ff,
    output logic             obj_bad_ff,
    output logic             motor_run_ff,
    output logic             motor_neg_ff,
    output logic      [31:0] speed_cmd_ff,
    output logic      [31:0] accel_cmd_ff,
    output logic      [31:0] home_pos_ff,
    output logic             home_set_ff
);
    import shs_pkg::*;

    // Registers: objects written by the master, plus flags, synchronisers and sequencer state.
    logic [15:0]   command_word_ff;   // Control bits from the master.
    logic [7:0]    req_mode_ff;       // Requested operating mode.
    logic [7:0]    act_mode_ff;       // Accepted operating mode.
    logic [7:0]    method_ff;         // Homing method selector.
    logic [31:0]   fast_speed_ff;     // Search speed.
    logic [31:0]   slow_speed_ff;     // Final approach speed.
    logic [31:0]   accel_ff;          // Acceleration and deceleration.
    logic [15:0]   fault_code_ff;     // Last fault reported.
    logic          error_ff;          // Sticky homing error flag.
    logic          attained_ff;       // Homing completed flag.
    logic          start_prev_ff;     // Previous start bit for edge finding.
    logic [3:0]    pin_meta_ff;       // First synchroniser stage.
    logic [3:0]    pin_sync_ff;       // Second synchroniser stage.
    logic [3:0]    pin_prev_ff;       // Delayed copy for edge finding.
    shs_state_type state_ff;          // Sequencer state.
    shs_state_type nxt_state;         // Next sequencer state.

    // Combinational decode of events.
    logic [3:0]    rise;              // Rising edges of the pins.
    logic [3:0]    fall;              // Falling edges of the pins.
    logic          start_edge;        // Rising edge of the start bit.
    logic [7:0]    base;              // Base sequence number.
    logic          is_switch;         // Method uses a switch as reference.
    logic          is_capture;        // Set-here method.
    logic          is_index_run;      // Method 33 or 34.
    logic          is_sequence;       // Methods 1 to 30.
    logic          fast_hit;          // Fast search found its switch.
    logic          ref_hit;           // Final reference event.
    logic          fault_hit;         // Forbidden switch became active.
    logic          homing_mode;       // Homing mode is active.
    logic [15:0]   state_word;        // Assembled state word.

    // Reduces methods 17 to 30 to the sequence they repeat.
    function automatic logic [7:0] base_of(input logic [7:0] m);
        base_of = (m >= METH_SWITCH_LO) ? m - METH_SWITCH_OFS : m;
    endfunction

    // Tells whether a base sequence first heads in negative direction.
    function automatic logic first_neg(input logic [7:0] b);
        first_neg = (b == 8'h01) || (b > METH_POS_LAST);
    endfunction

    // Two flip-flop synchroniser plus a delayed copy for edges.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_ff <= RST_PINS;
            pin_sync_ff <= RST_PINS;
            pin_prev_ff <= RST_PINS;
        end else begin
            pin_meta_ff <= {home_pin, pos_limit_pin, neg_limit_pin, index_pin};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // Event and method decode.
    always_comb begin
        rise         = pin_sync_ff & ~pin_prev_ff;
        fall         = ~pin_sync_ff & pin_prev_ff;
        start_edge   = command_word_ff[CW_START_BIT] & ~start_prev_ff;
        base         = base_of(method_ff);
        is_switch    = (method_ff >= METH_SWITCH_LO) && (method_ff <= METH_SWITCH_HI);
        is_sequence  = (method_ff != 8'h00) && (method_ff <= METH_SWITCH_HI);
        is_index_run = (method_ff == METH_NEG_INDEX) || (method_ff == METH_POS_INDEX);
        is_capture   = (method_ff == METH_SET_HERE_A) || (method_ff == METH_SET_HERE_B);
        homing_mode  = (act_mode_ff == MODE_HOMING);
        // Fast search ends on the limit (bases 1, 2) or home switch.
        if (base == 8'h01) begin
            fast_hit = rise[PIN_NEG_LIMIT];
        end else if (base == 8'h02) begin
            fast_hit = rise[PIN_POS_LIMIT];
        end else begin
            fast_hit = rise[PIN_HOME];
        end
        // Final reference: index pulse, or leaving the switch.
        if (is_index_run || !is_switch) begin
            ref_hit = rise[PIN_INDEX];
        end else if (base == 8'h01) begin
            ref_hit = fall[PIN_NEG_LIMIT];
        end else if (base == 8'h02) begin
            ref_hit = fall[PIN_POS_LIMIT];
        end else begin
            ref_hit = fall[PIN_HOME];
        end
        // Forbidden switches stop the run.
        if (is_index_run) begin
            fault_hit = |pin_sync_ff[PIN_HOME:PIN_NEG_LIMIT];
        end else if (base > METH_BASE_LAST) begin
            fault_hit = 1'b0;
        end else if (first_neg(base)) begin
            fault_hit = rise[PIN_POS_LIMIT];
        end else begin
            fault_hit = rise[PIN_NEG_LIMIT];
        end
        state_word = RST_WORD;
        state_word[SW_ERROR_BIT]    = error_ff;
        state_word[SW_ATTAINED_BIT] = attained_ff;
        state_word[SW_TARGET_BIT]   = attained_ff | error_ff;
    end

    // Next state of the sequencer.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SHS_IDLE: begin
                // Motion starts only in homing mode with the drive enabled.
                if (start_edge && homing_mode && drive_enabled) begin
                    if (is_index_run) begin
                        nxt_state = SHS_SLOW;
                    end else if (is_sequence) begin
                        nxt_state = SHS_FAST;
                    end
                end
            end
            SHS_FAST: begin
                if (fault_hit || !drive_enabled) begin
                    nxt_state = SHS_IDLE;
                end else if (fast_hit) begin
                    nxt_state = SHS_SLOW;
                end
            end
            SHS_SLOW: begin
                if (fault_hit || !drive_enabled) begin
                    nxt_state = SHS_IDLE;
                end else if (ref_hit) begin
                    nxt_state = SHS_DONE;
                end
            end
            SHS_DONE: begin
                nxt_state = SHS_IDLE;
            end
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= SHS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Motor command outputs follow the next state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            motor_run_ff <= 1'b0;
            motor_neg_ff <= 1'b0;
            speed_cmd_ff <= RST_DATA;
            accel_cmd_ff <= RST_DATA;
        end else begin
            motor_run_ff <= (nxt_state == SHS_FAST) || (nxt_state == SHS_SLOW);
            accel_cmd_ff <= accel_ff;
            if (nxt_state == SHS_FAST) begin
                motor_neg_ff <= first_neg(base);
                speed_cmd_ff <= fast_speed_ff;
            end else if (nxt_state == SHS_SLOW) begin
                // Index runs keep their direction; sequences reverse.
                if (is_index_run) begin
                    motor_neg_ff <= (method_ff == METH_NEG_INDEX);
                end else begin
                    motor_neg_ff <= !first_neg(base);
                end
                speed_cmd_ff <= slow_speed_ff;
            end else begin
                speed_cmd_ff <= RST_DATA;
            end
        end
    end

    // Home capture, flags and fault code.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            home_pos_ff   <= RST_DATA;
            home_set_ff   <= 1'b0;
            error_ff      <= 1'b0;
            attained_ff   <= 1'b0;
            fault_code_ff <= RST_WORD;
            start_prev_ff <= 1'b0;
        end else begin
            start_prev_ff <= command_word_ff[CW_START_BIT];
            home_set_ff   <= 1'b0;
            if (state_ff != SHS_IDLE && state_ff != SHS_DONE && nxt_state == SHS_IDLE) begin
                // Error set wins over the clear of a new start.
                error_ff      <= 1'b1;
                fault_code_ff <= FAULT_HOMING;
            end else if (start_edge && homing_mode) begin
                error_ff <= 1'b0;
            end
            if (start_edge && homing_mode && is_capture) begin
                // No drive enable is needed to set home here.
                home_pos_ff <= actual_position;
                home_set_ff <= 1'b1;
                attained_ff <= 1'b1;
            end else if (state_ff == SHS_DONE) begin
                home_pos_ff <= actual_position;
                home_set_ff <= 1'b1;
                attained_ff <= 1'b1;
            end else if (start_edge && homing_mode) begin
                attained_ff <= 1'b0;
            end
        end
    end

    // Object writes and mode acceptance.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            command_word_ff <= RST_WORD;
            req_mode_ff     <= RST_MODE;
            act_mode_ff     <= RST_MODE;
            method_ff       <= RST_MODE;
            fast_speed_ff   <= RST_DATA;
            slow_speed_ff   <= RST_DATA;
            accel_ff        <= RST_DATA;
        end else begin
            act_mode_ff <= req_mode_ff;
            if (obj_wr) begin
                unique case (obj_index)
                    OBJ_COMMAND_WORD: command_word_ff <= obj_wdata[15:0];
                    OBJ_REQ_MODE:     req_mode_ff     <= obj_wdata[7:0];
                    OBJ_HOME_METHOD:  method_ff       <= obj_wdata[7:0];
                    OBJ_HOME_ACCEL:   accel_ff        <= obj_wdata;
                    OBJ_HOME_SPEED: begin
                        if (obj_sub == SUB_FAST_SPEED) begin
                            fast_speed_ff <= obj_wdata;
                        end else if (obj_sub == SUB_SLOW_SPEED) begin
                            slow_speed_ff <= obj_wdata;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Object reads answer one cycle later; unknown indices flag bad.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            obj_rdata_ff <= RST_DATA;
            obj_ack_ff   <= 1'b0;
            obj_bad_ff   <= 1'b0;
        end else begin
            obj_ack_ff <= obj_rd | obj_wr;
            obj_bad_ff <= 1'b0;
            if (obj_rd) begin
                obj_rdata_ff <= RST_DATA;
                unique case (obj_index)
                    OBJ_FAULT_CODE:   obj_rdata_ff[15:0] <= fault_code_ff;
                    OBJ_COMMAND_WORD: obj_rdata_ff[15:0] <= command_word_ff;
                    OBJ_STATE_WORD:   obj_rdata_ff[15:0] <= state_word;
                    OBJ_REQ_MODE:     obj_rdata_ff[7:0]  <= req_mode_ff;
                    OBJ_ACT_MODE:     obj_rdata_ff[7:0]  <= act_mode_ff;
                    OBJ_HOME_METHOD:  obj_rdata_ff[7:0]  <= method_ff;
                    OBJ_HOME_ACCEL:   obj_rdata_ff       <= accel_ff;
                    OBJ_HOME_SPEED: begin
                        if (obj_sub == SUB_SLOW_SPEED) begin
                            obj_rdata_ff <= slow_speed_ff;
                        end else begin
                            obj_rdata_ff <= fast_speed_ff;
                        end
                    end
                    default: obj_bad_ff <= 1'b1;
                endcase
            end
        end
    end

endmodule

// File: shs_pkg.sv
// Shared constants and types of the servo homing sequencer.
package shs_pkg;

    // Object dictionary indices served on the object access port.
    localparam logic [15:0] OBJ_FAULT_CODE   = 16'h603f;
    localparam logic [15:0] OBJ_COMMAND_WORD = 16'h6040;
    localparam logic [15:0] OBJ_STATE_WORD   = 16'h6041;
    localparam logic [15:0] OBJ_REQ_MODE     = 16'h6060;
    localparam logic [15:0] OBJ_ACT_MODE     = 16'h6061;
    localparam logic [15:0] OBJ_HOME_METHOD  = 16'h6098;
    localparam logic [15:0] OBJ_HOME_SPEED   = 16'h6099;
    localparam logic [15:0] OBJ_HOME_ACCEL   = 16'h609a;

    // Sub-indices of the homing speed object.
    localparam logic [7:0]  SUB_FAST_SPEED   = 8'h01;
    localparam logic [7:0]  SUB_SLOW_SPEED   = 8'h02;

    // Field positions in the command word and the state word.
    localparam int          CW_START_BIT     = 4;
    localparam int          SW_TARGET_BIT    = 10;
    localparam int          SW_ATTAINED_BIT  = 12;
    localparam int          SW_ERROR_BIT     = 13;

    // Operating mode code that selects homing.
    localparam logic [7:0]  MODE_HOMING      = 8'h06;

    // Homing method codes with special handling.
    localparam logic [7:0]  METH_NEG_INDEX   = 8'h21;
    localparam logic [7:0]  METH_POS_INDEX   = 8'h22;
    localparam logic [7:0]  METH_SET_HERE_A  = 8'h23;
    localparam logic [7:0]  METH_SET_HERE_B  = 8'h25;
    localparam logic [7:0]  METH_SWITCH_OFS  = 8'h10;
    localparam logic [7:0]  METH_SWITCH_LO   = 8'h11;
    localparam logic [7:0]  METH_SWITCH_HI   = 8'h1e;
    localparam logic [7:0]  METH_BASE_LAST   = 8'h0e;
    localparam logic [7:0]  METH_POS_LAST    = 8'h0a;

    // Fault code reported after a homing error; the value is arbitrary.
    localparam logic [15:0] FAULT_HOMING     = 16'h0001;

    // Values after reset.
    localparam logic [15:0] RST_WORD         = 16'h0000;
    localparam logic [7:0]  RST_MODE         = 8'h00;
    localparam logic [31:0] RST_DATA         = 32'h0000_0000;
    localparam logic [3:0]  RST_PINS         = 4'h0;

    // Bit positions of the synchronised switch vector.
    localparam int          PIN_INDEX        = 0;
    localparam int          PIN_NEG_LIMIT    = 1;
    localparam int          PIN_POS_LIMIT    = 2;
    localparam int          PIN_HOME         = 3;

    // Sequencer states, Gray coded along idle, fast, slow, done.
    typedef enum logic [1:0] {
        SHS_IDLE = 2'b00,
        SHS_FAST = 2'b01,
        SHS_SLOW = 2'b11,
        SHS_DONE = 2'b10
    } shs_state_type;

endpackage

// File: shs_assertions.sv
`timescale 1ns/1ps
// Port-level watch on the homing sequencer.
module shs_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [15:0] obj_index,
    input wire logic        obj_wr,
    input wire logic        obj_rd,
    input wire logic [31:0] obj_wdata,
    input wire logic        drive_enabled,
    input wire logic        index_pin,
    input wire logic        neg_limit_pin,
    input wire logic        pos_limit_pin,
    input wire logic        home_pin,
    input wire logic [31:0] obj_rdata_ff,
    input wire logic        obj_ack_ff,
    input wire logic        obj_bad_ff,
    input wire logic        motor_run_ff,
    input wire logic        motor_neg_ff,
    input wire logic [31:0] accel_cmd_ff,
    input wire logic        home_set_ff
);
    import shs_pkg::*;
    logic [7:0]  mode_ff;  // Last requested operating mode.
    logic [7:0]  meth_ff;  // Last homing method written.
    logic [31:0] accel_ff; // Last acceleration written.
    logic        cw4_ff;   // Last start bit written.
    logic        start_ev; // Start bit rising while homing is selected.
    logic        index_m;  // An index-only method is selected.
    logic        move_m;   // A method that moves the motor is selected.
    assign start_ev = obj_wr && obj_index == OBJ_COMMAND_WORD && obj_wdata[CW_START_BIT]
                      && !cw4_ff && mode_ff == MODE_HOMING;
    assign index_m  = meth_ff == METH_NEG_INDEX || meth_ff == METH_POS_INDEX;
    assign move_m   = (meth_ff != RST_MODE && meth_ff <= METH_BASE_LAST) || index_m
                      || (meth_ff >= METH_SWITCH_LO && meth_ff <= METH_SWITCH_HI);
    // Mirrors the mode, method, acceleration and start bit the master writes, so starts can be predicted.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff  <= RST_MODE;
            meth_ff  <= RST_MODE;
            accel_ff <= RST_DATA;
            cw4_ff   <= 1'b0;
        end else if (obj_wr) begin
            case (obj_index)
                OBJ_REQ_MODE:     mode_ff <= obj_wdata[7:0];
                OBJ_HOME_METHOD:  meth_ff <= obj_wdata[7:0];
                OBJ_HOME_ACCEL:   accel_ff <= obj_wdata;
                OBJ_COMMAND_WORD: cw4_ff <= obj_wdata[CW_START_BIT];
                default:          ;
            endcase
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_start_move;
        start_ev && drive_enabled && move_m;
    endsequence
    sequence s_start_here;
        start_ev && (meth_ff == METH_SET_HERE_A || meth_ff == METH_SET_HERE_B);
    endsequence
    AST_ACK: assert property ((obj_wr || obj_rd) |=> obj_ack_ff)
        else $error("object access not acknowledged");
    AST_BAD_ZERO: assert property (obj_bad_ff |-> obj_ack_ff && obj_rdata_ff == RST_DATA)
        else $error("unknown object read did not return zero");
    AST_MODE_MIRROR: assert property (obj_rd && obj_index == OBJ_ACT_MODE
        |=> obj_rdata_ff[7:0] == $past(mode_ff, 2))
        else $error("active mode differs from requested mode");
    AST_ACCEL: assert property (!(obj_wr && obj_index == OBJ_HOME_ACCEL) [*2] |-> accel_cmd_ff == accel_ff)
        else $error("acceleration output differs from written value");
    AST_START_RUN: assert property (s_start_move |-> ##[2:3] motor_run_ff)
        else $error("motion did not start on start edge");
    AST_INDEX_DIR: assert property (s_start_move ##0 index_m |-> ##[2:3] motor_run_ff
        && motor_neg_ff == (meth_ff == METH_NEG_INDEX))
        else $error("index method moves the wrong way");
    AST_HERE_SET: assert property (s_start_here |-> ##[2:3] home_set_ff)
        else $error("position capture missing after start edge");
    AST_HERE_STILL: assert property (s_start_here |=> !motor_run_ff [*4])
        else $error("capture method moved the motor");
    AST_SW_STOP: assert property (motor_run_ff && index_m
        && (index_pin || neg_limit_pin || pos_limit_pin || home_pin) |-> ##[1:6] !motor_run_ff)
        else $error("index method kept running after a pin event");
    AST_HOME_PULSE: assert property (home_set_ff |-> !motor_run_ff ##1 !home_set_ff)
        else $error("home pulse too long or motor still running");
endmodule
bind shs_homing shs_checker shs_checker_i (.clk(clk), .nrst(nrst), .obj_index(obj_index),
    .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .drive_enabled(drive_enabled),
    .index_pin(index_pin), .neg_limit_pin(neg_limit_pin), .pos_limit_pin(pos_limit_pin),
    .home_pin(home_pin), .obj_rdata_ff(obj_rdata_ff), .obj_ack_ff(obj_ack_ff),
    .obj_bad_ff(obj_bad_ff), .motor_run_ff(motor_run_ff), .motor_neg_ff(motor_neg_ff),
    .accel_cmd_ff(accel_cmd_ff), .home_set_ff(home_set_ff));

// File: shs_master.sv
`timescale 1ns/1ps
// Network master: one object access at a time, strobe for one cycle, wait for ack.
module shs_master (
    input  wire logic        clk,
    output logic      [15:0] obj_index,
    output logic      [7:0]  obj_sub,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic      [31:0] obj_wdata,
    input  wire logic [31:0] obj_rdata_ff,
    input  wire logic        obj_ack_ff,
    input  wire logic        obj_bad_ff
);
    initial begin
        obj_index = 16'h0000;
        obj_sub   = 8'h00;
        obj_wr    = 1'b0;
        obj_rd    = 1'b0;
        obj_wdata = 32'h0000_0000;
    end
    // Writes carry method, speeds, acceleration and start edges.
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] data, output logic [31:0] rdata,
                          output logic bad, output logic ok);
        @(posedge clk);
        obj_index <= idx;
        obj_sub   <= sub;
        obj_wdata <= data;
        obj_wr    <= wr;
        obj_rd    <= !wr;
        @(posedge clk);
        obj_wr    <= 1'b0;
        obj_rd    <= 1'b0;
        obj_index <= ~idx;
        obj_wdata <= ~data;
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            #1;
            ok = obj_ack_ff === 1'b1;
            if (!ok) begin
                @(posedge clk);
            end
        end
        rdata = obj_rdata_ff;
        bad   = obj_bad_ff;
    endtask
endmodule

// File: test_servo_homing_sequencer.sv
`timescale 1ns/1ps
// Walks the sequencer through every switch method, index methods, errors and captures.
module test_servo_homing_sequencer;
    import shs_pkg::*;
    logic        clk, nrst, drive_enabled, obj_wr, obj_rd, obj_ack_ff, obj_bad_ff, bad;
    logic        motor_run_ff, motor_neg_ff, home_set_ff;
    logic [3:0]  pins;  // Switch levels by package pin position.
    logic [7:0]  obj_sub;
    logic [15:0] obj_index;
    logic [31:0] actual_position, obj_wdata, obj_rdata_ff, speed_cmd_ff, accel_cmd_ff;
    logic [31:0] home_pos_ff, fast, slow, rdata;
    int          fails, checked;
    shs_homing shs_homing_i (.clk(clk), .nrst(nrst), .obj_index(obj_index), .obj_sub(obj_sub),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .drive_enabled(drive_enabled),
        .actual_position(actual_position), .index_pin(pins[PIN_INDEX]),
        .neg_limit_pin(pins[PIN_NEG_LIMIT]), .pos_limit_pin(pins[PIN_POS_LIMIT]),
        .home_pin(pins[PIN_HOME]), .obj_rdata_ff(obj_rdata_ff), .obj_ack_ff(obj_ack_ff),
        .obj_bad_ff(obj_bad_ff), .motor_run_ff(motor_run_ff), .motor_neg_ff(motor_neg_ff),
        .speed_cmd_ff(speed_cmd_ff), .accel_cmd_ff(accel_cmd_ff), .home_pos_ff(home_pos_ff),
        .home_set_ff(home_set_ff));
    shs_master shs_master_i (.clk(clk), .obj_index(obj_index), .obj_sub(obj_sub),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata_ff(obj_rdata_ff),
        .obj_ack_ff(obj_ack_ff), .obj_bad_ff(obj_bad_ff));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] data);
        logic ok;
        shs_master_i.access(wr, idx, sub, data, rdata, bad, ok);
        if (!ok) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        access(1'b0, idx, 8'h00, RST_DATA);
        check(what, rdata, exp);
    endtask
    // Waits for run (0), home pulse (1) or direction (2) to reach a level.
    task automatic wait_for(input int sel, input logic lvl);
        logic seen;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            #1;
            seen = sel == 0 ? motor_run_ff : (sel == 1 ? home_set_ff : motor_neg_ff);
            if (seen === lvl) begin
                return;
            end
        end
        fails++;
        give_verdict();
    endtask
    task automatic set_pin(input int p, input logic v);
        @(posedge clk);
        pins[p] <= v;
    endtask
    task automatic start(input logic [7:0] m);
        access(1'b1, OBJ_HOME_METHOD, 8'h00, {24'h0, m});
        access(1'b1, OBJ_COMMAND_WORD, 8'h00, RST_DATA);
        access(1'b1, OBJ_COMMAND_WORD, 8'h00, 32'h10);
    endtask
    // Base methods 1 and 11..14 search negative first.
    function automatic logic first_neg(input logic [7:0] m);
        logic [7:0] b;
        b = m - METH_SWITCH_OFS;
        return b == 8'h01 || b > METH_POS_LAST;
    endfunction
    task automatic run_switch(input logic [7:0] m);
        int p;
        p = m == METH_SWITCH_LO ? PIN_NEG_LIMIT : (m == 8'h12 ? PIN_POS_LIMIT : PIN_HOME);
        start(m);
        wait_for(0, 1'b1);
        check("first direction", 32'(motor_neg_ff), 32'(first_neg(m)));
        check("search speed", speed_cmd_ff, fast);
        set_pin(p, 1'b1);
        wait_for(2, !first_neg(m));
        check("final speed", speed_cmd_ff, slow);
        set_pin(p, 1'b0);
        wait_for(1, 1'b1);
        check("home position", home_pos_ff, actual_position);
        rd_chk("attained", OBJ_STATE_WORD, 32'h1400);
    endtask
    task automatic run_err(input logic [7:0] m, input int p);
        start(m);
        wait_for(0, 1'b1);
        set_pin(p, 1'b1);
        wait_for(0, 1'b0);
        rd_chk("error state", OBJ_STATE_WORD, 32'h2400);
        rd_chk("fault code", OBJ_FAULT_CODE, {16'h0, FAULT_HOMING});
        set_pin(p, 1'b0);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        drive_enabled = 1'b1;
        pins = RST_PINS;
        fails = 0;
        checked = 0;
        void'($urandom(32'hcbd6));
        fast = $urandom;
        slow = $urandom;
        actual_position = $urandom;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd_chk("reset state", OBJ_STATE_WORD, RST_DATA);
        rd_chk("reset fault", OBJ_FAULT_CODE, RST_DATA);
        rd_chk("unmapped", 16'h6062, RST_DATA);
        check("unmapped flag", 32'(bad), 32'h1);
        access(1'b1, OBJ_HOME_ACCEL, 8'h00, fast ^ slow);
        rd_chk("reset mode", OBJ_ACT_MODE, RST_DATA);
        check("acceleration", accel_cmd_ff, fast ^ slow);
        access(1'b1, OBJ_REQ_MODE, 8'h00, 32'h6);
        rd_chk("mode shown", OBJ_ACT_MODE, 32'h6);
        access(1'b1, OBJ_ACT_MODE, 8'h00, 32'h3);
        rd_chk("mode read only", OBJ_ACT_MODE, 32'h6);
        access(1'b1, OBJ_HOME_SPEED, SUB_FAST_SPEED, fast);
        access(1'b1, OBJ_HOME_SPEED, SUB_SLOW_SPEED, slow);
        for (int m = 17; m <= 30; m++) begin
            run_switch(8'(m));
        end
        start(8'h01);
        set_pin(PIN_NEG_LIMIT, 1'b1);
        wait_for(2, 1'b0);
        @(posedge clk);
        pins <= 4'h1;
        wait_for(1, 1'b1);
        check("base home", home_pos_ff, actual_position);
        set_pin(PIN_INDEX, 1'b0);
        for (int k = 0; k < 2; k++) begin
            start(METH_NEG_INDEX + 8'(k));
            wait_for(0, 1'b1);
            check("index direction", 32'(motor_neg_ff), 32'(k == 0));
            set_pin(PIN_INDEX, 1'b1);
            wait_for(1, 1'b1);
            check("index stop", 32'(motor_run_ff), 32'h0);
            set_pin(PIN_INDEX, 1'b0);
        end
        for (int p = PIN_NEG_LIMIT; p <= PIN_HOME; p++) begin
            run_err(METH_NEG_INDEX + 8'(p % 2), p);
        end
        run_err(METH_SWITCH_LO + 8'h02, PIN_NEG_LIMIT);
        drive_enabled <= 1'b0;
        start(METH_POS_INDEX);
        repeat (4) @(posedge clk);
        check("no start disabled", 32'(motor_run_ff), 32'h0);
        for (int k = 0; k < 2; k++) begin
            actual_position <= $urandom;
            start(k == 0 ? METH_SET_HERE_A : METH_SET_HERE_B);
            wait_for(1, 1'b1);
            check("captured", home_pos_ff, actual_position);
            check("no motion", 32'(motor_run_ff), 32'h0);
        end
        give_verdict();
    end
endmodule
